/* pkg/stfc_pkg.sv */
// package for the serial transmit frame control block
package stfc_pkg;
   // register byte addresses
   localparam logic [3:0] STFC_CTRL_ONE_ADDR = 4'h0;
   localparam logic [3:0] STFC_CTRL_TWO_ADDR = 4'h4;
   localparam logic [3:0] STFC_DATA_ADDR     = 4'h8;
   localparam logic [3:0] STFC_STATUS_ADDR   = 4'hc;
   // field positions
   localparam int STFC_CNT_LSB   = 8;
   localparam int STFC_SIZE_LSB  = 5;
   localparam int STFC_COMP_LSB  = 3;
   localparam int STFC_IGN_BIT   = 2;
   localparam int STFC_DLY_LSB   = 0;
   localparam int STFC_PHASE_BIT = 15;
   // reset value and control-one write mask
   localparam logic [15:0] STFC_CTRL_RST = 16'h0000;
   localparam logic [15:0] STFC_ONE_MASK = 16'h7fe0;
   // axi responses
   localparam logic [1:0] STFC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] STFC_RESP_SLVERR = 2'h2;
   // compand modes
   typedef enum logic [1:0] {
      STFC_CMP_MSB  = 2'b00,
      STFC_CMP_LSB8 = 2'b01,
      STFC_CMP_MU   = 2'b10,
      STFC_CMP_A    = 2'b11
   } stfc_comp_t;
   // frame configuration carried to the link domain
   typedef struct packed {
      logic       phase_sel;
      logic [6:0] cnt1;
      logic [2:0] size1;
      logic [6:0] cnt2;
      logic [2:0] size2;
      logic [1:0] comp;
      logic       ignore;
      logic [1:0] delay;
   } stfc_cfg_t;
   // serial link outputs
   typedef struct packed {
      logic data;
      logic data_en;
   } stfc_link_t;
endpackage : stfc_pkg

/* hdl/stfc_top.sv */
// serial transmit frame control with axi4-lite registers
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module stfc_top
   import stfc_pkg::*;
(
   // system
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_SRST,
   // axi4-lite write
   input  wire logic [3:0]  I_AWADDR,
   input  wire logic        I_AWVALID,
   output logic             O_AWREADY,
   input  wire logic [31:0] I_WDATA,
   input  wire logic [3:0]  I_WSTRB,
   input  wire logic        I_WVALID,
   output logic             O_WREADY,
   output logic [1:0]       O_BRESP,
   output logic             O_BVALID,
   input  wire logic        I_BREADY,
   // axi4-lite read
   input  wire logic [3:0]  I_ARADDR,
   input  wire logic        I_ARVALID,
   output logic             O_ARREADY,
   output logic [31:0]      O_RDATA,
   output logic [1:0]       O_RRESP,
   output logic             O_RVALID,
   input  wire logic        I_RREADY,
   // serial link
   input  wire logic        I_TX_BIT_CLK,
   input  wire logic        I_TX_FRAME_SYNC_PIN,
   output logic             O_TX_DATA,
   output logic             O_TX_DATA_EN
);

////////////////////////////////////////////////////////////////////////////////
// functions

   function automatic logic [5:0] size_bits(input logic [2:0] code);
      case (code)
         3'h0:    size_bits = 6'd8;
         3'h1:    size_bits = 6'd12;
         3'h2:    size_bits = 6'd16;
         3'h3:    size_bits = 6'd20;
         3'h4:    size_bits = 6'd24;
         default: size_bits = 6'd32;
      endcase
   endfunction : size_bits

   // sign-magnitude compress, mu selects mu-law bias and segments
   function automatic logic [7:0] compress(input logic [15:0] s, input logic mu);
      logic [15:0] mag;
      logic [2:0]  seg;
      logic [3:0]  man;
      logic [7:0]  code;
      mag  = s[15] ? 16'(~s + 16'h1) : s;
      seg  = 3'h0;
      man  = 4'h0;
      code = 8'h00;
      if (mu) begin
         mag = (mag[15:2] > 14'd8158) ? 16'd8158 : 16'({2'b00, mag[15:2]});
         mag = 16'(mag + 16'd33);
         for (int i = 0; i < 8; i++) begin
            if (mag[i+5]) begin
               seg = 3'(i);
            end
         end
         man  = 4'(mag >> ({1'b0, seg} + 4'd1));
         code = ~{s[15], seg, man};
      end else begin
         mag = 16'(mag >> 3);
         for (int i = 1; i < 8; i++) begin
            if (mag[i+4]) begin
               seg = 3'(i);
            end
         end
         man  = (seg == 3'h0) ? 4'(mag >> 1) : 4'(mag >> seg);
         code = {~s[15], seg, man} ^ 8'h55;
      end
      compress = code;
   endfunction : compress

////////////////////////////////////////////////////////////////////////////////
// register slave

   logic [15:0] ctrl_one_q;
   logic [15:0] ctrl_two_q;
   logic [31:0] hold_q;
   logic        hold_tgl_q;
   logic        err_q;
   logic        aw_got_q;
   logic        w_got_q;
   logic [3:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic [2:0]  err_sync_q;
   logic [1:0]  busy_sync_q;
   logic        cfg_tgl_q;
   logic        awready_q;
   logic        wready_q;
   logic        arready_q;

   wire         wr_go   = aw_got_q && w_got_q && !bvalid_q;
   wire         wr_one  = wr_go && awaddr_q == STFC_CTRL_ONE_ADDR;
   wire         wr_two  = wr_go && awaddr_q == STFC_CTRL_TWO_ADDR;
   wire         wr_dat  = wr_go && awaddr_q == STFC_DATA_ADDR;
   wire         wr_sta  = wr_go && awaddr_q == STFC_STATUS_ADDR;
   wire         wr_ok   = wr_one || wr_two || wr_dat || wr_sta;
   wire         err_evt = err_sync_q[2] ^ err_sync_q[1];
   wire         err_clr = wr_sta && wstrb_q[0] && wdata_q[0];
   wire         rd_go   = I_ARVALID && !rvalid_q;
   wire         rd_ok   = I_ARADDR[1:0] == 2'b00;
   wire [15:0]  lo_mask = {wstrb_q[1] ? 8'hff : 8'h00, wstrb_q[0] ? 8'hff : 8'h00};
   wire [31:0]  w_mask  = {wstrb_q[3] ? 8'hff : 8'h00, wstrb_q[2] ? 8'hff : 8'h00, lo_mask};
   wire [15:0]  one_d   = ((ctrl_one_q & ~lo_mask) | (wdata_q[15:0] & lo_mask))
                          & STFC_ONE_MASK;
   wire [15:0]  two_d   = (ctrl_two_q & ~lo_mask) | (wdata_q[15:0] & lo_mask);
   wire [31:0]  rd_mux  =
      (I_ARADDR == STFC_CTRL_ONE_ADDR) ? {16'h0000, ctrl_one_q} :
      (I_ARADDR == STFC_CTRL_TWO_ADDR) ? {16'h0000, ctrl_two_q} :
      (I_ARADDR == STFC_DATA_ADDR)     ? hold_q :
      (I_ARADDR == STFC_STATUS_ADDR)   ? {30'h0, busy_sync_q[1], err_q} : 32'h0;
   wire         rd_hit  = rd_ok && I_ARADDR <= STFC_STATUS_ADDR;

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         ctrl_one_q <= STFC_CTRL_RST;
         ctrl_two_q <= STFC_CTRL_RST;
         hold_q     <= 32'h0;
         hold_tgl_q <= 1'b0;
         err_q      <= 1'b0;
         cfg_tgl_q  <= 1'b0;
      end else begin
         // announces new settings to the link side
         if (wr_one || wr_two) begin
            cfg_tgl_q <= ~cfg_tgl_q;
         end
         if (wr_one) begin
            ctrl_one_q <= one_d;
         end
         if (wr_two) begin
            ctrl_two_q <= two_d;
         end
         if (wr_dat) begin
            hold_q     <= (hold_q & ~w_mask) | (wdata_q & w_mask);
            hold_tgl_q <= ~hold_tgl_q;
         end
         // set beats clear in the same cycle
         err_q <= err_evt | (err_q & ~err_clr);
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         aw_got_q <= 1'b0;
         w_got_q  <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q  <= 32'h0;
         wstrb_q  <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q  <= STFC_RESP_OKAY;
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
      end else begin
         if (I_AWVALID && !aw_got_q) begin
            aw_got_q  <= 1'b1;
            awready_q <= 1'b0;
            awaddr_q  <= I_AWADDR;
         end
         if (I_WVALID && !w_got_q) begin
            w_got_q  <= 1'b1;
            wready_q <= 1'b0;
            wdata_q  <= I_WDATA;
            wstrb_q  <= I_WSTRB;
         end
         if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? STFC_RESP_OKAY : STFC_RESP_SLVERR;
         end else if (bvalid_q && I_BREADY) begin
            bvalid_q  <= 1'b0;
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
         rdata_q   <= 32'h0;
         rresp_q   <= STFC_RESP_OKAY;
      end else if (rd_go) begin
         rvalid_q  <= 1'b1;
         arready_q <= 1'b0;
         rdata_q   <= rd_hit ? rd_mux : 32'h0;
         rresp_q   <= rd_hit ? STFC_RESP_OKAY : STFC_RESP_SLVERR;
      end else if (I_RREADY) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   assign O_AWREADY = awready_q;
   assign O_WREADY  = wready_q;
   assign O_BVALID  = bvalid_q;
   assign O_BRESP   = bresp_q;
   assign O_ARREADY = arready_q;
   assign O_RVALID  = rvalid_q;
   assign O_RDATA   = rdata_q;
   assign O_RRESP   = rresp_q;

////////////////////////////////////////////////////////////////////////////////
// link domain: crossings

   logic [1:0]  cfg_sync_q;
   logic [1:0]  tgl_sync_q;
   logic [1:0]  fs_sync_q;
   logic        fs_prev_q;
   logic [1:0]  rst_sync_q;
   stfc_cfg_t   cfg_q;
   logic [31:0] hold_l_q;
   logic        hold_seen_q;
   logic        err_tgl_q;
   logic        cfg_seen_q;

   wire lrst = rst_sync_q[1];

   // settings are quasi-static; sampled after the toggle pair settles
   stfc_cfg_t cfg_sys;
   assign cfg_sys = '{phase_sel: ctrl_two_q[STFC_PHASE_BIT],
                      cnt1:  ctrl_one_q[STFC_CNT_LSB +: 7],
                      size1: ctrl_one_q[STFC_SIZE_LSB +: 3],
                      cnt2:  ctrl_two_q[STFC_CNT_LSB +: 7],
                      size2: ctrl_two_q[STFC_SIZE_LSB +: 3],
                      comp:  ctrl_two_q[STFC_COMP_LSB +: 2],
                      ignore: ctrl_two_q[STFC_IGN_BIT],
                      delay: ctrl_two_q[STFC_DLY_LSB +: 2]};

   always_ff @(posedge I_TX_BIT_CLK) begin
      rst_sync_q <= {rst_sync_q[0], I_SRST};
      fs_sync_q  <= {fs_sync_q[0], I_TX_FRAME_SYNC_PIN};
      tgl_sync_q <= {tgl_sync_q[0], hold_tgl_q};
      cfg_sync_q <= {cfg_sync_q[0], cfg_tgl_q};
   end

////////////////////////////////////////////////////////////////////////////////
// link domain: framing and shifting

   logic        active_q;
   logic [1:0]  dly_q;
   logic        in_delay_q;
   logic        phase2_q;
   logic [6:0]  word_q;
   logic [5:0]  bit_q;
   logic [31:0] shift_q;
   logic        tx_q;
   logic        tx_en_q;

   wire        fs_rise   = fs_sync_q[1] && !fs_prev_q;
   wire        unexpect  = fs_rise && active_q;
   wire        start     = fs_rise && (!active_q || !cfg_q.ignore);
   wire [6:0]  cur_cnt   = phase2_q ? cfg_q.cnt2 : cfg_q.cnt1;
   // phase of the word being loaded, phase 1 at frame start
   wire        ph2_next  = !start && (phase2_q || word_q == cur_cnt);
   wire [2:0]  cur_code  = phase2_q ? cfg_q.size2 : cfg_q.size1;
   wire [2:0]  nxt_code  = ph2_next ? cfg_q.size2 : cfg_q.size1;
   wire        comp8     = cfg_q.comp != STFC_CMP_MSB;
   wire [5:0]  cur_len   = comp8 ? 6'd8 : size_bits(cur_code);
   wire [5:0]  nxt_len   = comp8 ? 6'd8 : size_bits(nxt_code);
   wire [31:0] src       = hold_l_q;
   wire [7:0]  mu_byte   = compress(src[15:0], 1'b1);
   wire [7:0]  a_byte    = compress(src[15:0], 1'b0);
   wire [7:0]  lsb_byte  = {src[0], src[1], src[2], src[3], src[4], src[5], src[6], src[7]};
   wire [31:0] load_word =
      (cfg_q.comp == STFC_CMP_MU)   ? {mu_byte, 24'h0} :
      (cfg_q.comp == STFC_CMP_A)    ? {a_byte, 24'h0} :
      (cfg_q.comp == STFC_CMP_LSB8) ? {lsb_byte, 24'h0} :
      32'(src << (6'd32 - nxt_len));
   wire        last_bit  = bit_q == 6'(cur_len - 6'd1);
   wire        last_word = word_q == cur_cnt;
   wire        frame_end = last_bit && last_word && (phase2_q || !cfg_q.phase_sel);

   always_ff @(posedge I_TX_BIT_CLK) begin
      if (lrst) begin
         cfg_q       <= '0;
         hold_l_q    <= 32'h0;
         hold_seen_q <= 1'b0;
         fs_prev_q   <= 1'b0;
         err_tgl_q   <= 1'b0;
         cfg_seen_q  <= 1'b0;
      end else begin
         fs_prev_q <= fs_sync_q[1];
         if (!active_q && cfg_sync_q[1] != cfg_seen_q) begin
            cfg_q      <= cfg_sys;
            cfg_seen_q <= cfg_sync_q[1];
         end
         if (tgl_sync_q[1] != hold_seen_q) begin
            hold_l_q <= hold_q;
         end
         if (unexpect && !cfg_q.ignore) begin
            err_tgl_q <= ~err_tgl_q;
         end
         if (start || (active_q && !in_delay_q && last_bit)) begin
            hold_seen_q <= tgl_sync_q[1];
         end
      end
   end

   // word copied from holding register at frame start and at each word boundary
   always_ff @(posedge I_TX_BIT_CLK) begin
      if (lrst) begin
         active_q   <= 1'b0;
         in_delay_q <= 1'b0;
         dly_q      <= 2'h0;
         phase2_q   <= 1'b0;
         word_q     <= 7'h0;
         bit_q      <= 6'h0;
         shift_q    <= 32'h0;
         tx_q       <= 1'b0;
         tx_en_q    <= 1'b0;
      end else if (start) begin
         active_q   <= 1'b1;
         phase2_q   <= 1'b0;
         word_q     <= 7'h0;
         bit_q      <= 6'h0;
         dly_q      <= cfg_q.delay;
         in_delay_q <= cfg_q.delay != 2'h0;
         shift_q    <= load_word;
         tx_q       <= 1'b0;
         tx_en_q    <= 1'b0;
      end else if (active_q && in_delay_q) begin
         dly_q      <= 2'(dly_q - 2'h1);
         in_delay_q <= dly_q != 2'h1;
      end else if (active_q) begin
         tx_q    <= shift_q[31];
         tx_en_q <= 1'b1;
         if (last_bit) begin
            bit_q <= 6'h0;
            if (frame_end) begin
               active_q <= 1'b0;
            end else if (last_word) begin
               phase2_q <= 1'b1;
               word_q   <= 7'h0;
            end else begin
               word_q <= 7'(word_q + 7'h1);
            end
            shift_q <= load_word;
         end else begin
            bit_q   <= 6'(bit_q + 6'h1);
            shift_q <= {shift_q[30:0], 1'b0};
         end
      end else begin
         tx_en_q <= 1'b0;
      end
   end

   // error and busy back to the system clock
   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         err_sync_q    <= 3'h0;
         busy_sync_q   <= 2'h0;
      end else begin
         err_sync_q    <= {err_sync_q[1:0], err_tgl_q};
         busy_sync_q   <= {busy_sync_q[0], active_q};
      end
   end

   assign O_TX_DATA    = tx_q;
   assign O_TX_DATA_EN = tx_en_q;

endmodule : stfc_top

/* tb/stfc_assertions.sv */
// concurrent checks on the transmit frame control ports
`timescale 1ns/1ps
module stfc_assertions
   import stfc_pkg::*;
(
   // system
   input wire logic        I_SYS_CLK,
   input wire logic        I_SRST,
   // register bus
   input wire logic [3:0]  I_ARADDR,
   input wire logic        I_ARVALID,
   input wire logic        O_ARREADY,
   input wire logic [31:0] O_RDATA,
   input wire logic        O_RVALID,
   input wire logic        I_RREADY,
   input wire logic        I_AWVALID,
   input wire logic        O_AWREADY,
   input wire logic        I_WVALID,
   input wire logic        O_WREADY,
   input wire logic        O_BVALID,
   input wire logic        I_BREADY,
   // serial link
   input wire logic        I_TX_BIT_CLK,
   input wire logic        I_TX_FRAME_SYNC_PIN,
   input wire logic        O_TX_DATA_EN
);
   logic [3:0] rd_addr_q;
   // remembers which register the pending read targets
   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         rd_addr_q <= 4'h0;
      end else if (I_ARVALID && O_ARREADY) begin
         rd_addr_q <= I_ARADDR;
      end
   end
   a_b_answer: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID)
      else $error("no write reply");
   a_b_one_shot: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      O_BVALID && I_BREADY |=> !O_BVALID) else $error("write reply repeated");
   a_r_answer: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      I_ARVALID && O_ARREADY |=> O_RVALID) else $error("no read reply");
   a_r_one_shot: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      O_RVALID && I_RREADY |=> !O_RVALID) else $error("read reply repeated");
   a_ar_blocked: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      O_RVALID |-> !O_ARREADY) else $error("read taken while reply pending");
   a_wr_blocked: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      O_BVALID |-> !O_AWREADY && !O_WREADY) else $error("write taken while reply pending");
   a_reserved_zero: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      O_RVALID && rd_addr_q == STFC_CTRL_ONE_ADDR |-> O_RDATA[31:15] == 17'h0
      && O_RDATA[4:0] == 5'h0) else $error("reserved bits not zero");
   a_sync_start: assert property (@(posedge I_TX_BIT_CLK) disable iff (I_SRST)
      $rose(I_TX_FRAME_SYNC_PIN) && !O_TX_DATA_EN |-> ##[2:8] O_TX_DATA_EN)
      else $error("frame did not start");
   a_word_min: assert property (@(posedge I_TX_BIT_CLK) disable iff (I_SRST)
      $rose(O_TX_DATA_EN) |-> O_TX_DATA_EN[*8]) else $error("word shorter than 8 bits");
   c_frame: cover property (@(posedge I_TX_BIT_CLK) $rose(O_TX_DATA_EN));
   c_late_sync: cover property (@(posedge I_TX_BIT_CLK) $rose(I_TX_FRAME_SYNC_PIN) && O_TX_DATA_EN);
   c_write: cover property (@(posedge I_SYS_CLK) O_BVALID && I_BREADY);
endmodule : stfc_assertions

bind stfc_top stfc_assertions i_stfc_assertions (.*);

/* tb/stfc_partner.sv */
// far-end codec model: drives frame sync, captures the serial stream
`timescale 1ns/1ps
module stfc_partner (
   // link
   input  wire logic i_bit_clk,
   input  wire logic i_data,
   input  wire logic i_data_en,
   output logic      o_sync
);
   logic [63:0] rx_q = 64'h0;
   int          n_bits = 0;
   int          lat = 0;
   time         t_sync = 0;
   initial o_sync = 1'b0;
   // sample half a bit after launch
   always @(negedge i_bit_clk) begin
      if (i_data_en) begin
         rx_q <= {rx_q[62:0], i_data};
         n_bits <= n_bits + 1;
      end
   end
   // bit clocks from sync rise to first driven bit
   always @(posedge i_data_en) begin
      lat = int'(($time - t_sync) / 32);
   end
   // two-clock sync pulse; clr restarts the bit count
   task automatic sync(input logic clr);
      @(posedge i_bit_clk);
      o_sync <= 1'b1;
      t_sync = $time;
      if (clr) begin
         n_bits <= 0;
      end
      repeat (2) @(posedge i_bit_clk);
      o_sync <= 1'b0;
   endtask : sync
endmodule : stfc_partner

/* tb/tb.sv */
// self-checking bench for the serial transmit frame control block
`timescale 1ns/1ps
`define CHK(a, e) \
   begin \
      n_checks++; \
      if ((a) !== (e)) begin \
         n_mismatch++; \
         $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); \
      end \
   end
module tb
   import stfc_pkg::*;
;
   logic        I_SYS_CLK = 1'b0;
   logic        I_SRST = 1'b1;
   logic        I_TX_BIT_CLK = 1'b0;
   logic [3:0]  I_AWADDR = 4'h0;
   logic [3:0]  I_ARADDR = 4'h0;
   logic [3:0]  I_WSTRB = 4'hf;
   logic [31:0] I_WDATA = 32'h0;
   logic        I_AWVALID = 1'b0;
   logic        I_WVALID = 1'b0;
   logic        I_BREADY = 1'b0;
   logic        I_ARVALID = 1'b0;
   logic        I_RREADY = 1'b0;
   logic        O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_TX_DATA, O_TX_DATA_EN;
   logic [1:0]  O_BRESP, O_RRESP, rr;
   logic [31:0] O_RDATA, rd;
   logic        I_TX_FRAME_SYNC_PIN;
   int          n_mismatch = 0;
   int          n_checks = 0;
   int          wlen [6] = '{8, 12, 16, 20, 24, 32};
   always #12.5 I_SYS_CLK = ~I_SYS_CLK;
   always #16 I_TX_BIT_CLK = ~I_TX_BIT_CLK;
   stfc_top i_stfc_top (.*);
   stfc_partner i_stfc_partner (
      .i_bit_clk (I_TX_BIT_CLK),
      .i_data    (O_TX_DATA),
      .i_data_en (O_TX_DATA_EN),
      .o_sync    (I_TX_FRAME_SYNC_PIN)
   );
   ////////////////////////////////////////////////////////////////////////////////
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge I_SYS_CLK);
      {I_AWADDR, I_WDATA, I_AWVALID, I_WVALID, I_BREADY} <= {a, d, 3'b111};
      fork
         begin
            do @(posedge I_SYS_CLK); while (O_AWREADY !== 1'b1);
            I_AWVALID <= 1'b0;
         end
         begin
            do @(posedge I_SYS_CLK); while (O_WREADY !== 1'b1);
            I_WVALID <= 1'b0;
         end
      join
      while (O_BVALID !== 1'b1) @(posedge I_SYS_CLK);
      rr = O_BRESP;
      I_BREADY <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [3:0] a);
      @(posedge I_SYS_CLK);
      {I_ARADDR, I_ARVALID, I_RREADY} <= {a, 2'b11};
      do @(posedge I_SYS_CLK); while (O_ARREADY !== 1'b1);
      I_ARVALID <= 1'b0;
      while (O_RVALID !== 1'b1) @(posedge I_SYS_CLK);
      {rd, rr} = {O_RDATA, O_RRESP};
      I_RREADY <= 1'b0;
   endtask : axi_rd
   // settings change only while the link is idle
   task automatic cfg(input logic [15:0] one, input logic [15:0] two);
      axi_wr(STFC_CTRL_ONE_ADDR, {16'h0, one});
      axi_wr(STFC_CTRL_TWO_ADDR, {16'h0, two});
   endtask : cfg
   task automatic frame(input logic [31:0] d, input int nb);
      axi_wr(STFC_DATA_ADDR, d);
      i_stfc_partner.sync(1'b1);
      repeat (nb + 12) @(posedge I_TX_BIT_CLK);
   endtask : frame
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      axi_rd(STFC_CTRL_ONE_ADDR);
      `CHK(rd, 32'h0)
      axi_rd(STFC_CTRL_TWO_ADDR);
      `CHK(rd, 32'h0)
      axi_wr(STFC_CTRL_ONE_ADDR, 32'hffbf);
      axi_rd(STFC_CTRL_ONE_ADDR);
      `CHK(rd, {16'h0, 16'hffbf & STFC_ONE_MASK})
      axi_wr(STFC_CTRL_TWO_ADDR, 32'hffbe);
      axi_rd(STFC_CTRL_TWO_ADDR);
      `CHK(rd, 32'hffbe)
      axi_rd(4'h2);
      `CHK(rr, STFC_RESP_SLVERR)
      axi_wr(4'h6, 32'h1);
      `CHK(rr, STFC_RESP_SLVERR)
      $display("regs done");
   endtask : t_regs
   task automatic t_sizes();
      logic [63:0] m;
      for (int i = 0; i < 6; i++) begin
         m = (64'h1 << wlen[i]) - 64'h1;
         cfg({8'h0, i[2:0], 5'h0}, 16'h0);
         frame(32'h89abcdef, wlen[i]);
         `CHK(i_stfc_partner.n_bits, wlen[i])
         `CHK(i_stfc_partner.rx_q & m, 64'h89abcdef & m)
      end
      $display("sizes done");
   endtask : t_sizes
   task automatic t_dual();
      cfg({8'h0, 3'd1, 5'h0}, {1'b1, 7'd1, 3'd2, 5'h0});
      frame(32'h0000abcd, 44);
      `CHK(i_stfc_partner.n_bits, 44)
      `CHK(i_stfc_partner.rx_q[43:0], {12'hbcd, 16'habcd, 16'habcd})
      $display("dual done");
   endtask : t_dual
   task automatic t_compand();
      logic [7:0] cexp [3] = '{8'h83, 8'hff, 8'hd5};
      for (int i = 1; i < 4; i++) begin
         cfg({8'h0, 3'd5, 5'h0}, {11'h0, i[1:0], 3'h0});
         frame({24'h0, i == 1 ? 8'hc1 : 8'h00}, 8);
         `CHK(i_stfc_partner.n_bits, 8)
         `CHK(i_stfc_partner.rx_q[7:0], cexp[i-1])
      end
      $display("compand done");
   endtask : t_compand
   // sync to first bit: three clocks to take the sync, one to launch
   task automatic t_delay();
      for (int d = 0; d < 3; d++) begin
         cfg(16'h0, {14'h0, d[1:0]});
         frame(32'ha5, 8);
         `CHK(i_stfc_partner.lat, 4 + d)
      end
      $display("delay done");
   endtask : t_delay
   // second sync lands in the second word of a four-word frame
   task automatic abort_run(input logic ign, input logic [31:0] d2);
      cfg({1'b0, 7'd3, 8'h0}, {13'h0, ign, 2'h0});
      axi_wr(STFC_DATA_ADDR, 32'h5a);
      i_stfc_partner.sync(1'b1);
      repeat (12) @(posedge I_TX_BIT_CLK);
      axi_wr(STFC_DATA_ADDR, d2);
      i_stfc_partner.sync(1'b0);
      repeat (44) @(posedge I_TX_BIT_CLK);
      axi_rd(STFC_STATUS_ADDR);
   endtask : abort_run
   task automatic t_abort();
      abort_run(1'b1, 32'h5a);
      `CHK(i_stfc_partner.n_bits, 32)
      `CHK(i_stfc_partner.rx_q[31:0], 32'h5a5a5a5a)
      `CHK(rd[0], 1'b0)
      abort_run(1'b0, 32'hc3);
      `CHK(i_stfc_partner.rx_q[31:0], 32'hc3c3c3c3)
      `CHK(rd[0], 1'b1)
      axi_wr(STFC_STATUS_ADDR, 32'h1);
      axi_rd(STFC_STATUS_ADDR);
      `CHK(rd[0], 1'b0)
      $display("abort done");
   endtask : t_abort
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (6) @(posedge I_SYS_CLK);
      I_SRST <= 1'b0;
      t_regs();
      t_sizes();
      t_dual();
      t_compand();
      t_delay();
      t_abort();
      print_verdict();
   end
   initial begin
      #1000000;
      n_mismatch++;
      print_verdict();
   end
endmodule : tb
